// ===== hw/fbbs_exec.sv
// Summary of operation
// - Half-carry set: branch to pc+offset+1 when H is 1, flags kept, one or two cycles.
// - Half-carry clear: branch to pc+offset+1 when H is 0, flags kept.
// - Transfer set: branch when T is 1, else sequential, flags kept.
// - Transfer clear: branch when T is 0, else sequential, flags kept.
// - Overflow set: branch when V is 1, flags kept.
// - Overflow clear: branch when V is 0, flags kept.
// - Interrupts enabled: branch when I is 1, flags kept, one or two cycles.
// - Interrupts disabled: branch when I is 0, flags kept, one or two cycles.
// - I/O bit set: force selected bit to 1, others and flags kept, two cycles.
// - I/O bit clear: force selected bit to 0, flags kept, two cycles.
// - Left shift: bits move up, bit zero gets 0, Z C N V S updated, one cycle.
// - Right shift: bits move down, bit seven gets 0, Z C N V S updated, one cycle.
module fbbs_exec
	import fbbs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Instruction issue
	input  wire logic        instr_valid_i,
	input  fbbs_instr_s      instr_i,
	input  wire logic [15:0] pc_i,
	input  fbbs_flags_s      flags_i,
	// I/O space read data for the addressed register
	input  wire logic [7:0]  io_rdata_i,
	// Core status
	output logic             busy_o,
	output logic             done_o,
	// Program counter update
	output logic             pc_we_o,
	output logic [15:0]      pc_o,
	// Flag update
	output logic             flags_we_o,
	output fbbs_flags_s      flags_o,
	// Register file write
	output logic             rd_we_o,
	output logic [7:0]       rd_wdata_o,
	// I/O space access
	output logic             io_re_o,
	output logic             io_we_o,
	output logic [4:0]       io_addr_o,
	output logic [7:0]       io_wdata_o
);
	typedef enum logic [1:0] {ST_IDLE, ST_BRANCH, ST_IO} fbbs_state_e;

	fbbs_state_e state_r, state_nxt;
	logic        busy_r, busy_nxt;
	logic        done_r, done_nxt;
	logic        pc_we_r, pc_we_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic        flags_we_r, flags_we_nxt;
	fbbs_flags_s flags_r, flags_nxt;
	logic        rd_we_r, rd_we_nxt;
	logic [7:0]  rd_wdata_r, rd_wdata_nxt;
	logic        io_re_r, io_re_nxt;
	logic        io_we_r, io_we_nxt;
	logic [4:0]  io_addr_r, io_addr_nxt;
	logic [7:0]  io_wdata_r, io_wdata_nxt;
	logic        io_set_r, io_set_nxt;
	logic [2:0]  bit_r, bit_nxt;

	logic        is_branch;
	logic        cond;
	logic [15:0] target;
	logic [7:0]  shifted;
	logic        shift_out;
	logic        shift_zero;
	logic        shift_neg;
	logic        shift_ovf;

	// Branch condition and shift datapath
	always_comb begin
		is_branch = 1'b1;
		cond      = 1'b0;
		unique case (instr_i.op)
			OP_BRANCH_HALF_CARRY_SET:      cond = flags_i.half_carry;
			OP_BRANCH_HALF_CARRY_CLEAR:    cond = !flags_i.half_carry;
			OP_BRANCH_TRANSFER_FLAG_SET:   cond = flags_i.transfer;
			OP_BRANCH_TRANSFER_FLAG_CLEAR: cond = !flags_i.transfer;
			OP_BRANCH_OVERFLOW_SET:        cond = flags_i.overflow;
			OP_BRANCH_OVERFLOW_CLEAR:      cond = !flags_i.overflow;
			OP_BRANCH_IRQ_ENABLED:         cond = flags_i.irq_en;
			OP_BRANCH_IRQ_DISABLED:        cond = !flags_i.irq_en;
			default:                       is_branch = 1'b0;
		endcase
		// Sign-extended offset plus one
		target = pc_i + {{(PC_W - $bits(instr_i.offset)){instr_i.offset[$bits(instr_i.offset) - 1]}},
			instr_i.offset} + PC_ONE;
		if (instr_i.op == OP_LOGICAL_LEFT_SHIFT) begin
			shifted   = {instr_i.rd_val[MSB-1:0], 1'b0};
			shift_out = instr_i.rd_val[MSB];
		end else begin
			shifted   = {1'b0, instr_i.rd_val[MSB:1]};
			shift_out = instr_i.rd_val[0];
		end
		// Flag results shared by both shifts
		shift_zero = (shifted == BYTE_ZERO);
		shift_neg  = shifted[MSB];
		shift_ovf  = shift_neg ^ shift_out;
	end

	// Next state and output strobes
	always_comb begin
		state_nxt    = state_r;
		busy_nxt     = 1'b0;
		done_nxt     = 1'b0;
		pc_we_nxt    = 1'b0;
		pc_nxt       = pc_r;
		flags_we_nxt = 1'b0;
		flags_nxt    = flags_r;
		rd_we_nxt    = 1'b0;
		rd_wdata_nxt = rd_wdata_r;
		io_re_nxt    = 1'b0;
		io_we_nxt    = 1'b0;
		io_addr_nxt  = io_addr_r;
		io_wdata_nxt = io_wdata_r;
		io_set_nxt   = io_set_r;
		bit_nxt      = bit_r;
		unique case (state_r)
			ST_IDLE: begin
				if (instr_valid_i) begin
					if (is_branch) begin
						if (cond) begin
							// Taken: extra cycle for the PC load
							state_nxt = ST_BRANCH;
							busy_nxt  = 1'b1;
							pc_nxt    = target;
						end else begin
							done_nxt = 1'b1;
						end
					end else if (instr_i.op == OP_IO_BIT_SET ||
						instr_i.op == OP_IO_BIT_CLEAR) begin
						// Read cycle, then modify-write cycle
						state_nxt   = ST_IO;
						busy_nxt    = 1'b1;
						io_re_nxt   = 1'b1;
						io_addr_nxt = instr_i.io_addr;
						io_set_nxt  = (instr_i.op == OP_IO_BIT_SET);
						bit_nxt     = instr_i.bit_sel;
					end else if (instr_i.op == OP_LOGICAL_LEFT_SHIFT ||
						instr_i.op == OP_LOGICAL_RIGHT_SHIFT) begin
						done_nxt             = 1'b1;
						rd_we_nxt            = 1'b1;
						rd_wdata_nxt         = shifted;
						flags_we_nxt         = 1'b1;
						flags_nxt            = flags_i;
						flags_nxt.carry      = shift_out;
						flags_nxt.zero       = shift_zero;
						flags_nxt.negative   = shift_neg;
						flags_nxt.overflow   = shift_ovf;
						flags_nxt.sign       = shift_neg ^ shift_ovf;
					end
				end
			end
			ST_BRANCH: begin
				// Second cycle: load the new PC
				state_nxt = ST_IDLE;
				pc_we_nxt = 1'b1;
				done_nxt  = 1'b1;
			end
			ST_IO: begin
				state_nxt    = ST_IDLE;
				io_we_nxt    = 1'b1;
				done_nxt     = 1'b1;
				// Merge the forced bit into the read data
				io_wdata_nxt = io_rdata_i;
				io_wdata_nxt[bit_r] = io_set_r;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// State and output registers
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_r    <= ST_IDLE;
			busy_r     <= 1'b0;
			done_r     <= 1'b0;
			pc_we_r    <= 1'b0;
			pc_r       <= PC_RESET;
			flags_we_r <= 1'b0;
			flags_r    <= FLAGS_RST;
			rd_we_r    <= 1'b0;
			rd_wdata_r <= BYTE_ZERO;
			io_re_r    <= 1'b0;
			io_we_r    <= 1'b0;
			io_addr_r  <= '0;
			io_wdata_r <= BYTE_ZERO;
			io_set_r   <= 1'b0;
			bit_r      <= '0;
		end else begin
			state_r    <= state_nxt;
			busy_r     <= busy_nxt;
			done_r     <= done_nxt;
			pc_we_r    <= pc_we_nxt;
			pc_r       <= pc_nxt;
			flags_we_r <= flags_we_nxt;
			flags_r    <= flags_nxt;
			rd_we_r    <= rd_we_nxt;
			rd_wdata_r <= rd_wdata_nxt;
			io_re_r    <= io_re_nxt;
			io_we_r    <= io_we_nxt;
			io_addr_r  <= io_addr_nxt;
			io_wdata_r <= io_wdata_nxt;
			io_set_r   <= io_set_nxt;
			bit_r      <= bit_nxt;
		end
	end

	// Outputs taken straight from the registers
	assign busy_o     = busy_r;
	assign done_o     = done_r;
	assign pc_we_o    = pc_we_r;
	assign pc_o       = pc_r;
	assign flags_we_o = flags_we_r;
	assign flags_o    = flags_r;
	assign rd_we_o    = rd_we_r;
	assign rd_wdata_o = rd_wdata_r;
	assign io_re_o    = io_re_r;
	assign io_we_o    = io_we_r;
	assign io_addr_o  = io_addr_r;
	assign io_wdata_o = io_wdata_r;
endmodule

// ===== hw/fbbs_pkg.sv
package fbbs_pkg;
	// Operation selector
	typedef enum logic [3:0] {
		OP_NONE,
		OP_BRANCH_HALF_CARRY_SET,
		OP_BRANCH_HALF_CARRY_CLEAR,
		OP_BRANCH_TRANSFER_FLAG_SET,
		OP_BRANCH_TRANSFER_FLAG_CLEAR,
		OP_BRANCH_OVERFLOW_SET,
		OP_BRANCH_OVERFLOW_CLEAR,
		OP_BRANCH_IRQ_ENABLED,
		OP_BRANCH_IRQ_DISABLED,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_LOGICAL_LEFT_SHIFT,
		OP_LOGICAL_RIGHT_SHIFT
	} fbbs_op_e;

	// Status register bit layout
	typedef struct packed {
		logic irq_en;
		logic transfer;
		logic half_carry;
		logic sign;
		logic overflow;
		logic negative;
		logic zero;
		logic carry;
	} fbbs_flags_s;

	// Decoded instruction
	typedef struct packed {
		fbbs_op_e   op;
		logic [6:0] offset;
		logic [4:0] io_addr;
		logic [2:0] bit_sel;
		logic [7:0] rd_val;
	} fbbs_instr_s;

	localparam int          PC_W       = 16;
	localparam logic [15:0] PC_ONE     = 16'h0001;
	localparam logic [15:0] PC_RESET   = 16'h0000;
	localparam logic [7:0]  BYTE_ZERO  = 8'h00;
	localparam logic [7:0]  FLAGS_RST  = 8'h00;
	localparam int          MSB        = 7;
endpackage

// ===== tb/fbbs_exec_asserts.sv
module fbbs_exec_chk
	import fbbs_pkg::*;
(
	input wire logic	clk_sys_i,
	input wire logic	rst_i,
	input wire logic	instr_valid_i,
	input fbbs_instr_s	instr_i,
	input wire logic	busy_o,
	input wire logic	done_o,
	input wire logic	pc_we_o,
	input wire logic	flags_we_o,
	input fbbs_flags_s	flags_o,
	input wire logic	rd_we_o,
	input wire logic [7:0]	rd_wdata_o,
	input wire logic	io_re_o,
	input wire logic	io_we_o,
	input wire logic [4:0]	io_addr_o
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic	iss;
	assign iss = instr_valid_i && !busy_o;
	lsl_result_a: assert property (iss && instr_i.op == OP_LOGICAL_LEFT_SHIFT |=>
		rd_we_o && rd_wdata_o == {$past(instr_i.rd_val[6:0]), 1'b0}) else $error("bad lsl");
	lsr_result_a: assert property (iss && instr_i.op == OP_LOGICAL_RIGHT_SHIFT |=>
		rd_wdata_o == {1'b0, $past(instr_i.rd_val[7:1])}
		&& flags_o.carry == $past(instr_i.rd_val[0])) else $error("bad lsr");
	shift_flags_a: assert property (rd_we_o |-> flags_we_o && flags_o.negative ==
		rd_wdata_o[7] && flags_o.zero == (rd_wdata_o == 8'h00)) else $error("bad flags");
	io_seq_a: assert property (iss && instr_i.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} |=>
		io_re_o && busy_o ##1 io_we_o && done_o) else $error("bad io timing");
	io_addr_a: assert property (io_re_o |-> io_addr_o == $past(instr_i.io_addr))
		else $error("bad io addr");
	flags_kept_a: assert property (iss && instr_i.op inside
		{[OP_BRANCH_HALF_CARRY_SET:OP_IO_BIT_CLEAR]} |=> !flags_we_o) else $error("flag write");
	pc_late_a: assert property (pc_we_o |-> done_o && $past(busy_o))
		else $error("pc write early");
	busy_once_a: assert property (busy_o |=> !busy_o) else $error("busy too long");
endmodule
bind fbbs_exec fbbs_exec_chk chk_u (.*);

// ===== tb/fbbs_exec_test.sv
module test_fbbs_exec import fbbs_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic	clk_sys_i, rst_i, instr_valid_i, busy_o, done_o, pc_we_o, flags_we_o;
	logic	rd_we_o, io_re_o, io_we_o, t;
	logic [15:0]	pc_i, pc_o;
	logic [7:0]	io_rdata_i, rd_wdata_o, io_wdata_o, r;
	logic [4:0]	io_addr_o;
	logic [19:0]	e, q[$];
	fbbs_instr_s	instr_i;
	fbbs_flags_s	flags_i, flags_o, f;
	int	n_mismatch, comparisons, seed;
	fbbs_exec dut_u (
		.clk_sys_i     (clk_sys_i),
		.rst_i         (rst_i),
		.instr_valid_i (instr_valid_i),
		.instr_i       (instr_i),
		.pc_i          (pc_i),
		.flags_i       (flags_i),
		.io_rdata_i    (io_rdata_i),
		.busy_o        (busy_o),
		.done_o        (done_o),
		.pc_we_o       (pc_we_o),
		.pc_o          (pc_o),
		.flags_we_o    (flags_we_o),
		.flags_o       (flags_o),
		.rd_we_o       (rd_we_o),
		.rd_wdata_o    (rd_wdata_o),
		.io_re_o       (io_re_o),
		.io_we_o       (io_we_o),
		.io_addr_o     (io_addr_o),
		.io_wdata_o    (io_wdata_o)
	);
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		#20000;
		n_mismatch++;
		print_verdict;
	end
	task automatic chk(input string nm, input logic [19:0] s, x);
		comparisons++;
		if (s !== x) begin
			n_mismatch++;
			$display("[ERR] %s exp %h seen %h", nm, x, s);
		end
	endtask
	// Strobes, then PC, I/O data or flags and result
	always @(posedge clk_sys_i) begin
		if (done_o === 1'b1) begin
			e = q.size() ? q.pop_front() : '1;
			chk("result", {pc_we_o, io_we_o, rd_we_o, flags_we_o, pc_we_o ? pc_o : io_we_o ?
				{8'h00, io_wdata_o} : rd_we_o ? {flags_o, rd_wdata_o} : 16'h0000}, e);
		end
	end
	task automatic go(input fbbs_op_e o);
		@(posedge clk_sys_i) #1;
		instr_i = 27'($random(seed));
		instr_i.op = o;
		flags_i = 8'($random(seed));
		pc_i = 16'($random(seed));
		io_rdata_i = 8'($random(seed));
		instr_valid_i = 1'b1;
		f = flags_i;
		r = io_rdata_i;
		r[instr_i.bit_sel] = o == OP_IO_BIT_SET;
		t = o != OP_NONE;
		case (o)
			OP_BRANCH_HALF_CARRY_SET: t = f.half_carry;
			OP_BRANCH_HALF_CARRY_CLEAR: t = !f.half_carry;
			OP_BRANCH_TRANSFER_FLAG_SET: t = f.transfer;
			OP_BRANCH_TRANSFER_FLAG_CLEAR: t = !f.transfer;
			OP_BRANCH_OVERFLOW_SET: t = f.overflow;
			OP_BRANCH_OVERFLOW_CLEAR: t = !f.overflow;
			OP_BRANCH_IRQ_ENABLED: t = f.irq_en;
			OP_BRANCH_IRQ_DISABLED: t = !f.irq_en;
			OP_LOGICAL_LEFT_SHIFT: {f.carry, r} = {instr_i.rd_val, 1'b0};
			OP_LOGICAL_RIGHT_SHIFT: {r, f.carry} = {1'b0, instr_i.rd_val};
			default: ;
		endcase
		f.zero = r == 8'h00;
		f.negative = r[7];
		f.overflow = r[7] ^ f.carry;
		f.sign = r[7] ^ f.overflow;
		if (o >= OP_LOGICAL_LEFT_SHIFT) begin
			q.push_back({4'b0011, f, r});
			t = 1'b0;
		end else if (o >= OP_IO_BIT_SET) begin
			q.push_back({4'b0100, 8'h00, r});
		end else if (o != OP_NONE) begin
			q.push_back(t ? {4'b1000, pc_i + {{9{instr_i.offset[6]}}, instr_i.offset}
				+ PC_ONE} : 20'h0_0000);
		end
		// Issue held during busy must be ignored
		@(posedge clk_sys_i) #1;
		instr_valid_i = t;
		instr_i.op = OP_LOGICAL_LEFT_SHIFT;
		@(posedge clk_sys_i) #1;
		instr_valid_i = 1'b0;
		repeat (2) @(posedge clk_sys_i);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		seed = 70068;
		rst_i = 1'b1;
		instr_valid_i = 1'b0;
		instr_i = '0;
		pc_i = 16'h0000;
		flags_i = '0;
		io_rdata_i = 8'h00;
		repeat (5) @(posedge clk_sys_i);
		#1;
		rst_i = 1'b0;
		for (int i = 0; i < 13; i++) begin
			repeat (8) go(fbbs_op_e'(i));
			$display("test op %0d done", i);
		end
		chk("queue left", 20'(q.size()), 20'h0_0000);
		print_verdict;
	end
endmodule
